// ---- rtl/ampc_map.svh ----
// register offsets, bus address, defaults and timing counts for the amp controller
`ifndef AMPC_MAP_SVH
`define AMPC_MAP_SVH
`define AMPC_DEV_ADDR 7'h58
`define AMPC_REG_CTRL 8'h01
`define AMPC_REG_LAST 8'h07
`define AMPC_CTRL_DEFAULT 8'hc3
`define AMPC_BIT_RIGHT_EN 7
`define AMPC_BIT_LEFT_EN 6
`define AMPC_BIT_SOFT_SD 5
`define AMPC_BIT_FAULT_R 4
`define AMPC_BIT_FAULT_L 3
`define AMPC_CLK_MHZ 50
`define AMPC_SEQ_TIME_US 10000
`define AMPC_SEQ_CYCLES (`AMPC_SEQ_TIME_US * `AMPC_CLK_MHZ)
`define AMPC_SCL_DIV 8'd125
`endif

// ---- rtl/ampc_pkg.sv ----
// types shared by the amp controller
package ampc_pkg;
  typedef enum logic [1:0] {
    AMPC_OP_WRITE,
    AMPC_OP_READ,
    AMPC_OP_NONE
  } ampc_op_t;
endpackage

// ---- rtl/ampc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ampc_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      dout <= s1_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ampc_seq_timer.sv ----
// guard timer that holds off new orders during start-up or shutdown
`timescale 1ns/100ps
`default_nettype none
module ampc_seq_timer #(
  parameter int unsigned CYCLES = 500000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  output logic busy
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
    end else if (start) begin
      cnt_q <= CYCLES;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end
  assign busy = (cnt_q != 32'h0);
endmodule
`default_nettype wire

// ---- rtl/ampc_ctrl.sv ----
// i2c master controller for the amplifier control port and shutdown pin
`timescale 1ns/100ps
`default_nettype none
`include "ampc_map.svh"
// Operation
// - bytes shift as eight bits, msb first
// - receiver acknowledges in the ninth clock period
// - start is sda fall with scl high; stop is sda rise with scl high
// - data bits change only while scl low
// - each transaction: start, 7-bit address plus direction, stop
// - write uses direction 0; device acks address, register, data
// - multi-byte write sends several data bytes, each acknowledged
// - read: address+0, register, repeated start, address+1, then data
// - after last read byte master sends nack then stop
// - start-up sequence is not interrupted once begun
// - shutdown sequence is not interrupted once begun
// - master acks every read byte except the last
module ampc_ctrl
  import ampc_pkg::*;
#(
  parameter int unsigned SEQ_CYCLES = `AMPC_SEQ_CYCLES,
  parameter int unsigned MAXLEN = 8
) (
  input wire logic clk,
  input wire logic nrst,
  // user orders
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [7:0] req_reg,
  input wire logic [3:0] req_len,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] wr_index,
  input wire logic wr_load,
  input wire logic shutdown_req,
  output logic done,
  output logic nack_err,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  // pins
  output logic shutdown_pin_n,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic scl_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic sda_i
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_RSTART, ST_STOP, ST_WAIT
  } ampc_st_t;
  // ===========================================================
  // write buffer and pin sync
  logic [7:0] wbuf_q [MAXLEN];
  logic sda_s, scl_s;
  always_ff @(posedge clk) begin
    if (wr_load) begin
      wbuf_q[wr_index] <= wr_data;
    end
  end
  ampc_sync u_sda (.clk(clk), .nrst(nrst), .din(sda_i), .dout(sda_s));
  ampc_sync u_scl (.clk(clk), .nrst(nrst), .din(scl_i), .dout(scl_s));
  // ===========================================================
  // shutdown pin and sequence guard
  // pin changes and soft shutdown flips share one guard timer
  logic sd_q, seq_busy, soft_flip;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sd_q <= 1'b0;
    end else if (!seq_busy) begin
      sd_q <= shutdown_req;
    end
  end
  assign shutdown_pin_n = !sd_q;
  ampc_seq_timer #(.CYCLES(SEQ_CYCLES)) u_seq (
    .clk(clk),
    .nrst(nrst),
    .start((sd_q != shutdown_req && !seq_busy) || soft_flip),
    .busy(seq_busy)
  );
  // ===========================================================
  // bit engine: four phases per scl period
  ampc_st_t st_q;
  ampc_op_t op_q;
  logic [7:0] div_q;
  logic [1:0] ph_q;
  logic tick;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q, len_q;
  logic [7:0] reg_q;
  logic phase2_q, rx_q;
  logic scl_q, sda_q;
  assign tick = (div_q == `AMPC_SCL_DIV);
  always_ff @(posedge clk) begin
    if (!nrst || st_q == ST_IDLE) begin
      div_q <= 8'h0;
    end else if (tick) begin
      div_q <= 8'h0;
    // released scl still low: device stretches, so the divider waits
    end else if (!(scl_q && !scl_s)) begin
      div_q <= div_q + 8'h1;
    end
  end
  // orders wait out the guard and any shutdown
  assign req_ready = (st_q == ST_IDLE) && !seq_busy && !sd_q;
  assign busy = !req_ready;
  // ===========================================================
  // open-drain pins: outputs only ever pull low
  assign scl_o = 1'b0;
  assign scl_oe_n = scl_q;
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      op_q <= AMPC_OP_NONE;
      ph_q <= 2'd0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= 8'h0;
      bit_q <= 3'd0;
      byte_q <= 4'd0;
      len_q <= 4'd0;
      reg_q <= 8'h0;
      phase2_q <= 1'b0;
      rx_q <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      rd_data <= 8'h0;
      rd_valid <= 1'b0;
    end else begin
      done <= 1'b0;
      rd_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          scl_q <= 1'b1;
          sda_q <= 1'b1;
          if (req_valid && req_ready) begin
            op_q <= req_read ? AMPC_OP_READ : AMPC_OP_WRITE;
            reg_q <= req_reg;
            len_q <= (req_len == 4'd0) ? 4'd1 : req_len;
            nack_err <= 1'b0;
            phase2_q <= 1'b0;
            ph_q <= 2'd0;
            st_q <= ST_START;
          end
        end
        ST_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) begin
            sda_q <= 1'b0;
          end else if (ph_q == 2'd1) begin
            scl_q <= 1'b0;
            sh_q <= {`AMPC_DEV_ADDR, phase2_q};
            rx_q <= 1'b0;
            bit_q <= 3'd7;
            byte_q <= 4'd0;
            ph_q <= 2'd0;
            st_q <= ST_BIT;
          end
        end
        ST_BIT: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_q <= rx_q ? 1'b1 : sh_q[7];
            2'd1: scl_q <= 1'b1;
            2'd2: if (rx_q) begin
              sh_q <= {sh_q[6:0], sda_s};
            end
            default: begin
              scl_q <= 1'b0;
              if (!rx_q) begin
                sh_q <= {sh_q[6:0], 1'b0};
              end
              bit_q <= bit_q - 3'd1;
              if (bit_q == 3'd0) begin
                st_q <= ST_ACK;
              end
            end
          endcase
        end
        ST_ACK: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: begin
              // acknowledge every read byte except the last
              sda_q <= rx_q ? (byte_q + 4'd1 >= len_q) : 1'b1;
            end
            2'd1: scl_q <= 1'b1;
            2'd2: if (!rx_q && sda_s) begin
              nack_err <= 1'b1;
            end
            default: begin
              scl_q <= 1'b0;
              ph_q <= 2'd0;
              bit_q <= 3'd7;
              if (rx_q) begin
                rd_data <= sh_q;
                rd_valid <= 1'b1;
                byte_q <= byte_q + 4'd1;
                st_q <= (byte_q + 4'd1 >= len_q) ? ST_STOP : ST_BIT;
              end else if (nack_err) begin
                st_q <= ST_STOP;
              end else if (phase2_q) begin
                rx_q <= 1'b1;
                st_q <= ST_BIT;
              end else if (byte_q == 4'd0) begin
                sh_q <= reg_q;
                byte_q <= 4'd1;
                st_q <= ST_BIT;
              end else if (op_q == AMPC_OP_READ) begin
                phase2_q <= 1'b1;
                st_q <= ST_RSTART;
              end else if (byte_q > len_q) begin
                st_q <= ST_STOP;
              end else begin
                sh_q <= wbuf_q[byte_q[2:0] - 3'd1];
                byte_q <= byte_q + 4'd1;
                st_q <= ST_BIT;
              end
            end
          endcase
        end
        ST_RSTART: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) begin
            sda_q <= 1'b1;
          end else if (ph_q == 2'd1) begin
            scl_q <= 1'b1;
            ph_q <= 2'd0;
            st_q <= ST_START;
          end
        end
        ST_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_q <= 1'b0;
            2'd1: scl_q <= 1'b1;
            2'd2: sda_q <= 1'b1;
            default: st_q <= ST_WAIT;
          endcase
        end
        ST_WAIT: begin
          done <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  // ===========================================================
  // soft shutdown shadow: a write that flips the bit opens a guard
  logic [3:0] len_eff;
  logic [7:0] soft_off;
  logic soft_q, soft_new_q, soft_hit_q;
  assign len_eff = (req_len == 4'd0) ? 4'd1 : req_len;
  // offset of the control register in the order; wraps like the pointer
  assign soft_off = `AMPC_REG_CTRL - req_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_hit_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      soft_hit_q <= !req_read && (soft_off < {4'h0, len_eff});
    end
  end
  // buffer entry that lands in the control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      soft_new_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      soft_new_q <= wbuf_q[soft_off[2:0]][`AMPC_BIT_SOFT_SD];
    end
  end
  // pin low puts the device back to defaults, bit clear
  always_ff @(posedge clk) begin
    if (!nrst || sd_q) begin
      soft_q <= 1'b0;
    end else if (soft_flip) begin
      soft_q <= soft_new_q;
    end
  end
  // only an acknowledged write that really flips the bit counts
  assign soft_flip = (st_q == ST_WAIT) && soft_hit_q && !nack_err && !sd_q
    && (soft_new_q != soft_q);
endmodule
`default_nettype wire

// ---- dv/ampc_ctrl_asserts.sv ----
// port checker for the amp controller
`timescale 1ns/100ps
`default_nettype none
module ampc_ctrl_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_read,
  input wire logic busy,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic shutdown_req,
  input wire logic shutdown_pin_n,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd_q;
  always_ff @(posedge clk) begin
    if (!nrst) rd_q <= 1'b0;
    else if (req_valid && req_ready) rd_q <= req_read;
  end
  // ====
  // bus steps, read bytes, shutdown guard and done pulse
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  sequence s_held;
    !req_ready [*8];
  endsequence
  a_start_first: assert property (
    req_valid && req_ready |-> ##[1:400] s_start) else $error("no start");
  a_stop_done: assert property (
    $rose(sda_oe_n) && scl_oe_n |-> ##[1:400] done) else $error("no done");
  a_no_skew: assert property (
    $changed(scl_oe_n) |-> $stable(sda_oe_n)) else $error("sda skew");
  a_scl_high: assert property (
    $rose(scl_oe_n) |-> scl_oe_n [*8]) else $error("short scl high");
  a_rd_read: assert property (
    rd_valid |-> rd_q && busy) else $error("stray read byte");
  a_guard_hold: assert property (
    $changed(shutdown_pin_n) |=> s_held) else $error("order in guard");
  a_pin_follow: assert property (
    shutdown_req && shutdown_pin_n && !busy && !req_valid
      |-> ##[1:4] !shutdown_pin_n) else $error("pin not low");
  a_done_pulse: assert property (
    done |=> !done) else $error("long done");
endmodule
bind ampc_ctrl ampc_ctrl_asserts chk_u (.clk(clk), .nrst(nrst),
  .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
  .busy(busy), .done(done), .rd_valid(rd_valid),
  .shutdown_req(shutdown_req), .shutdown_pin_n(shutdown_pin_n),
  .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
`default_nettype wire

// ---- dv/ampc_dev_model.sv ----
// behavioural amplifier control port on the serial bus
`timescale 1ns/100ps
`default_nettype none
module ampc_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic sd_n,
  output logic pull
);
  localparam logic [63:0] DEF = 64'h00c3050b00063ac2;
  logic [7:0] mem [0:255];
  logic [7:0] sh, tx, ptr;
  logic act = 1'b0, rd = 1'b0, mnak = 1'b0, a;
  int n = 9, st = 0;
  task automatic reload;
    int i;
    for (i = 0; i < 256; i++) mem[i] = (i < 8) ? DEF[63-8*i -: 8] : 8'h00;
    ptr = 8'h00;
    pull = 1'b0;
  endtask
  // ====
  // bus slave
  initial reload();
  always @(negedge sd_n) reload();
  always @(negedge sda) if (scl) begin
    n = 9;
    st = 0;
    mnak = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) begin
    if (n < 8 && !(act && rd && st > 0)) sh = {sh[6:0], sda};
    if (n == 8 && act && rd && st > 0) mnak = sda;
  end
  always @(negedge scl) begin
    n = (n >= 8) ? 0 : n + 1;
    a = (n == 8) && !(act && rd && st > 0);
    if (a && st == 0) begin
      act = (sh[7:1] == 7'h58);
      rd = sh[0];
    end else if (a && act && st == 1) ptr = sh;
    else if (a && act) begin
      if (ptr == 8'h01) sh[4:3] = sh[4:3] & mem[1][4:3];
      mem[ptr] = sh;
      ptr = ptr + 8'h01;
    end
    if (a) st = st + 1;
    if (n == 0 && act && rd && st > 0 && !mnak) begin
      tx = mem[ptr];
      ptr = ptr + 8'h01;
    end
    pull = a ? act : (act && rd && st > 0 && n < 8 && !mnak && !tx[7-n]);
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the amp controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [63:0] DEF = 64'h00c3050b00063ac2;
  logic clk, nrst, req_valid, req_ready, req_read, wr_load, shutdown_req;
  logic done, nack_err, rd_valid, busy, shutdown_pin_n;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, pull;
  logic [7:0] req_reg, wr_data, rd_data;
  logic [3:0] req_len;
  logic [2:0] wr_index;
  logic [7:0] ex [0:7];
  int miscompares = 0, cmp_count = 0, i;
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & !pull;
  ampc_ctrl #(.SEQ_CYCLES(50)) dut_u (.clk, .nrst, .req_valid, .req_ready,
    .req_read, .req_reg, .req_len, .wr_data, .wr_index, .wr_load,
    .shutdown_req, .done, .nack_err, .rd_data, .rd_valid, .busy,
    .shutdown_pin_n, .scl_o, .scl_oe_n, .scl_i(scl), .sda_o, .sda_oe_n,
    .sda_i(sda));
  ampc_dev_model dev_u (.scl(scl), .sda(sda), .sd_n(shutdown_pin_n),
    .pull(pull));
  // ====
  // helpers
  function automatic logic [7:0] dflt(input int r);
    return DEF[63-8*r -: 8];
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic load(input logic [2:0] ix, input logic [7:0] v);
    wr_load <= 1'b1;
    wr_index <= ix;
    wr_data <= v;
    @(posedge clk);
    wr_load <= 1'b0;
    @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic [7:0] r, input logic [3:0] l);
    int k, j;
    k = 0;
    for (j = 0; j < 600 && req_ready !== 1'b1; j++) @(posedge clk);
    if (j == 600) begin
      miscompares++;
      test_done();
    end
    req_valid <= 1'b1;
    req_read <= rd;
    req_reg <= r;
    req_len <= l;
    @(posedge clk);
    req_valid <= 1'b0;
    for (j = 0; j < 60000 && done !== 1'b1; j++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        chk("rd_data", ex[r + k], rd_data);
        k++;
      end
    end
    if (j == 60000) begin
      miscompares++;
      test_done();
    end
    chk("nack_err", 8'h00, {7'h0, nack_err});
    if (rd) chk("read bytes", {4'h0, l}, 8'(k));
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {nrst, req_valid, req_read, wr_load, shutdown_req} = 5'h00;
    {req_reg, wr_data, req_len, wr_index} = 23'h0;
    for (i = 0; i < 8; i++) ex[i] = dflt(i);
    ex[2] = 8'($urandom(69521));
    ex[3] = 8'($urandom());
    ex[1] = 8'h20;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    load(3'h0, ex[1]);
    load(3'h1, ex[2]);
    load(3'h2, ex[3]);
    xfer(1'b0, 8'h01, 4'h3);
    chk("req_ready", 8'h00, {7'h0, req_ready});
    xfer(1'b1, 8'h01, 4'h3);
    $display("test write then read ended");
    shutdown_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk("shutdown_pin_n", 8'h00, {7'h0, shutdown_pin_n});
    chk("req_ready", 8'h00, {7'h0, req_ready});
    shutdown_req <= 1'b0;
    for (i = 0; i < 8; i++) ex[i] = dflt(i);
    xfer(1'b1, 8'h01, 4'h1);
    $display("test shutdown ended");
    test_done();
  end
endmodule
`default_nettype wire
